// ==== rtl/opmc_pkg.sv ====
// Notes on behaviour
// - drive mode bit 0 up to 10 MHz
// - fast enable write clears then sets stable
// - speed-up bit selects quick start mode
// - slow enable write clears then sets stable
// - select 111 in normal enters slow mode
// - slow switch waits for chosen source stable
// - select 000-110 returns normal, divide 1-64
// - keep-alive bits pick sleep or idle mode
// - sleep stops all but slow rc; idle_sub_only keeps sub only
// - idle_both_clocks both, idle_fast_only fast only, cpu halted
// - halt freezes execution, state retained
// - halt sets powerdown, clears timeout flag
// - halt clears watchdog, counting resumes
// - wake on port edge, interrupt, watchdog
// - powerdown cleared by reset or clear-watchdog
// - halted watchdog overflow resets pc and sp
// - per-pin wake enable; resume after halt
// - disabled or stack full interrupt resumes only
// - already pending interrupt does not wake
// - high source bit picks rc or crystal
// - low source bit picks rc or crystal
package opmc_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SYSCTL   = 8'h00; // clock select and keep-alive
  localparam logic [7:0] ADDR_FASTXTAL = 8'h04; // fast_crystal_control
  localparam logic [7:0] ADDR_SLOWXTAL = 8'h08; // slow_crystal_control
  localparam logic [7:0] ADDR_WAKE     = 8'h0C; // port a wake enables
  localparam logic [7:0] ADDR_STATUS   = 8'h10; // read-only status
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SEL_LSB   = 5; // sysclk_select 7:5
  localparam int HFS_BIT   = 3; // high_freq_source_sel
  localparam int LFS_BIT   = 2; // low_freq_source_sel
  localparam int FKA_BIT   = 1; // fast_osc_keepalive
  localparam int SKA_BIT   = 0; // slow_osc_keepalive
  localparam int MODE_BIT  = 2; // drive mode / speedup
  localparam int FLAG_BIT  = 1; // stable flag
  localparam int EN_BIT    = 0; // oscillator enable
  localparam int PD_BIT    = 0; // status powerdown_flag
  localparam int TO_BIT    = 1; // status watchdog_timeout_flag
  localparam int STATE_LSB = 2; // status mode 4:2
  localparam int HRC_BIT   = 5; // status fast_rc_stable_flag
  localparam int LRC_BIT   = 6; // status slow rc ready
  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] SYSCTL_RST = 8'h00;
  localparam logic [2:0] SEL_SUB    = 3'h7; // sub_clock source
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_DEC   = 2'h3;
  // operating modes, gray along normal-switch-slow
  typedef enum logic [2:0] {
    OPMC_NORMAL = 3'h0,
    OPMC_SWITCH = 3'h1,
    OPMC_SLOW   = 3'h3,
    OPMC_WAKE   = 3'h2,
    OPMC_SLEEP  = 3'h6,
    OPMC_IDLE_SUB_ONLY  = 3'h7,
    OPMC_IDLE_BOTH_CLOCKS  = 3'h5,
    OPMC_IDLE_FAST_ONLY  = 3'h4
  } opmc_state_e;
endpackage

// ==== rtl/opmc_top.sv ====
`timescale 1ns/1ps
module opmc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // core events, same clock
  input  wire logic        halt_exec,
  input  wire logic        clr_wdt_exec,
  input  wire logic        wdt_overflow,
  input  wire logic [7:0]  irq_request,
  input  wire logic [7:0]  irq_enable,
  input  wire logic        stack_full,
  // pins and oscillator ready levels, asynchronous
  input  wire logic [7:0]  porta_pin,
  input  wire logic        fast_crystal_osc_ready,
  input  wire logic        slow_crystal_osc_ready,
  input  wire logic        fast_rc_osc_ready,
  input  wire logic        slow_rc_osc_ready,
  // oscillator controls
  output logic             fast_crystal_osc_en,
  output logic             fast_xtal_drive_mode,
  output logic             slow_crystal_osc_en,
  output logic             slow_xtal_speedup,
  output logic             slow_rc_osc_en,
  // clock tree and core controls
  output logic             high_speed_clock_run,
  output logic             sub_clock_run,
  output logic             cpu_clock_run,
  output logic             sysclk_use_sub,
  output logic [2:0]       sysclk_divide,
  output logic             watchdog_clear,
  output logic             pc_sp_reset,
  output logic             resume_after_halt,
  output logic             irq_service
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]  sysctl;                 // select, sources, keep-alive
  logic        fast_xtal_enable;       // fast crystal enable bit
  logic        fast_xtal_stable_flag;  // read-only stable flag
  logic        slow_xtal_enable;       // slow crystal enable bit
  logic        slow_xtal_stable_flag;  // read-only stable flag
  logic [7:0]  porta_wake_enable;      // per-pin wake enables
  logic        powerdown_flag;         // set by halt
  logic        watchdog_timeout_flag;  // set by overflow
  logic [11:0] sync1;                  // first synchroniser stage
  logic [11:0] sync2;                  // second synchroniser stage
  logic [7:0]  porta_prev;             // for falling edge detect
  logic [7:0]  irq_at_halt;            // requests pending at halt
  logic        wake_by_irq;            // latched wake cause
  logic        aw_held;                // write address captured
  logic        w_held;                 // write data captured
  logic [7:0]  aw_addr;                // captured write address
  logic [31:0] w_data;                 // captured write data
  logic [3:0]  w_strb;                 // captured byte enables
  opmc_pkg::opmc_state_e state;        // operating mode
  opmc_pkg::opmc_state_e next_state;   // next operating mode
  logic        do_write;               // both halves present
  logic        wr_byte0;               // low byte enabled
  logic [7:0]  porta_s;                // synced port pins
  logic        fast_xtal_ready_s;      // synced fast crystal ready
  logic        slow_xtal_ready_s;      // synced slow crystal ready
  logic        fast_rc_stable_flag;    // synced fast rc ready
  logic        slow_rc_ready_s;        // synced slow rc ready
  logic        running;                // core executing
  logic        halt_take;              // halt accepted
  logic        halted;                 // sleep or an idle mode
  logic [7:0]  port_fall;              // enabled falling edges
  logic [7:0]  irq_new;                // requests raised since halt
  logic        wake;                   // any wake source
  logic        target_stable;          // selected source ready
  logic        hs_stable;              // high_speed_clock stable
  logic        sub_stable;             // sub_clock stable

  // true when a write of the low byte hits the given address
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = do_write && wr_byte0 && (aw_addr == a);
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // two flops on every asynchronous level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // pins idle high, so no false falling edge after reset
      sync1 <= 12'h0FF;
      sync2 <= 12'h0FF;
    end else begin
      sync1 <= {slow_rc_osc_ready, fast_rc_osc_ready, slow_crystal_osc_ready,
                fast_crystal_osc_ready, porta_pin};
      sync2 <= sync1;
    end
  end

  assign porta_s             = sync2[7:0];
  assign fast_xtal_ready_s   = sync2[8];
  assign slow_xtal_ready_s   = sync2[9];
  assign fast_rc_stable_flag = sync2[10];
  assign slow_rc_ready_s     = sync2[11];

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign awready  = !aw_held && !bvalid;
  assign wready   = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_byte0 = w_strb[0];

  // capture address and data in either order, answer once both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= opmc_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        // unmapped addresses answer decode error
        if (aw_addr == opmc_pkg::ADDR_SYSCTL || aw_addr == opmc_pkg::ADDR_FASTXTAL ||
            aw_addr == opmc_pkg::ADDR_SLOWXTAL || aw_addr == opmc_pkg::ADDR_WAKE ||
            aw_addr == opmc_pkg::ADDR_STATUS) begin
          bresp <= opmc_pkg::RESP_OKAY;
        end else begin
          bresp <= opmc_pkg::RESP_DEC;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  assign arready = !rvalid;

  // register read data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= opmc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= opmc_pkg::RESP_OKAY;
      rdata  <= 32'h0000_0000;
      unique case (araddr)
        opmc_pkg::ADDR_SYSCTL: begin
          rdata[7:0] <= sysctl;
        end
        opmc_pkg::ADDR_FASTXTAL: begin
          rdata[2:0] <= {fast_xtal_drive_mode, fast_xtal_stable_flag, fast_xtal_enable};
        end
        opmc_pkg::ADDR_SLOWXTAL: begin
          rdata[2:0] <= {slow_xtal_speedup, slow_xtal_stable_flag, slow_xtal_enable};
        end
        opmc_pkg::ADDR_WAKE: begin
          rdata[7:0] <= porta_wake_enable;
        end
        opmc_pkg::ADDR_STATUS: begin
          rdata[opmc_pkg::PD_BIT]  <= powerdown_flag;
          rdata[opmc_pkg::TO_BIT]  <= watchdog_timeout_flag;
          rdata[opmc_pkg::STATE_LSB +: 3] <= state;
          rdata[opmc_pkg::HRC_BIT] <= fast_rc_stable_flag;
          rdata[opmc_pkg::LRC_BIT] <= slow_rc_ready_s;
        end
        default: begin
          rresp <= opmc_pkg::RESP_DEC;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // system control and wake enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysctl            <= opmc_pkg::SYSCTL_RST;
      porta_wake_enable <= 8'h00;
    end else begin
      if (wr_hit(opmc_pkg::ADDR_SYSCTL)) begin
        sysctl <= w_data[7:0] & 8'hEF; // bit 4 reads zero
      end
      if (wr_hit(opmc_pkg::ADDR_WAKE)) begin
        porta_wake_enable <= w_data[7:0];
      end
    end
  end

  // fast crystal: enable, drive mode, stable flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_xtal_enable      <= 1'b0;
      fast_xtal_drive_mode  <= 1'b0;
      fast_xtal_stable_flag <= 1'b0;
    end else begin
      if (wr_hit(opmc_pkg::ADDR_FASTXTAL)) begin
        fast_xtal_enable <= w_data[opmc_pkg::EN_BIT];
        // mode frozen while enabled
        if (!fast_xtal_enable) begin
          fast_xtal_drive_mode <= w_data[opmc_pkg::MODE_BIT];
        end
      end
      // enabling clears the flag first, ready sets it after
      if (wr_hit(opmc_pkg::ADDR_FASTXTAL) && w_data[opmc_pkg::EN_BIT] && !fast_xtal_enable) begin
        fast_xtal_stable_flag <= 1'b0;
      end else if (!fast_xtal_enable) begin
        fast_xtal_stable_flag <= 1'b0;
      end else begin
        // follows the crystal, so a stopped one reads unstable
        fast_xtal_stable_flag <= fast_xtal_ready_s;
      end
    end
  end

  // slow crystal: enable, speed-up, stable flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_xtal_enable      <= 1'b0;
      slow_xtal_speedup     <= 1'b0;
      slow_xtal_stable_flag <= 1'b0;
    end else begin
      if (wr_hit(opmc_pkg::ADDR_SLOWXTAL)) begin
        slow_xtal_enable <= w_data[opmc_pkg::EN_BIT];
        // speed-up frozen while slow crystal clocks the system
        if (!(sysclk_use_sub && sysctl[opmc_pkg::LFS_BIT])) begin
          slow_xtal_speedup <= w_data[opmc_pkg::MODE_BIT];
        end
      end
      if (wr_hit(opmc_pkg::ADDR_SLOWXTAL) && w_data[opmc_pkg::EN_BIT] && !slow_xtal_enable) begin
        slow_xtal_stable_flag <= 1'b0;
      end else if (!slow_xtal_enable) begin
        slow_xtal_stable_flag <= 1'b0;
      end else begin
        // follows the crystal, so a stopped one reads unstable
        slow_xtal_stable_flag <= slow_xtal_ready_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // source selection and wake detection
  // ---------------------------------------------------------------
  assign hs_stable  = sysctl[opmc_pkg::HFS_BIT] ? fast_xtal_stable_flag
                                                : fast_rc_stable_flag;
  assign sub_stable = sysctl[opmc_pkg::LFS_BIT] ? slow_xtal_stable_flag
                                                : slow_rc_ready_s;
  assign target_stable = (sysctl[7:5] == opmc_pkg::SEL_SUB) ? sub_stable
                                                            : hs_stable;
  assign running   = (state == opmc_pkg::OPMC_NORMAL) || (state == opmc_pkg::OPMC_SLOW) ||
                     (state == opmc_pkg::OPMC_SWITCH);
  assign halt_take = running && halt_exec;
  assign halted    = !running && (state != opmc_pkg::OPMC_WAKE);
  assign port_fall = porta_prev & ~porta_s & porta_wake_enable;
  assign irq_new   = irq_request & ~irq_at_halt;
  assign wake      = halted && ((|port_fall) || (|irq_new) || wdt_overflow);

  // edge history and requests pending at halt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      porta_prev  <= 8'hFF;
      irq_at_halt <= 8'h00;
      wake_by_irq <= 1'b0;
    end else begin
      porta_prev <= porta_s;
      if (halt_take) begin
        irq_at_halt <= irq_request;
      end
      // serve only an enabled request with stack room
      if (wake) begin
        wake_by_irq <= |(irq_new & irq_enable) && !stack_full;
      end
    end
  end

  // ---------------------------------------------------------------
  // operating mode machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      opmc_pkg::OPMC_NORMAL, opmc_pkg::OPMC_SLOW, opmc_pkg::OPMC_SWITCH: begin
        if (halt_exec) begin
          // keep-alive pair picks the low power mode
          unique case (sysctl[1:0])
            2'b00: next_state = opmc_pkg::OPMC_SLEEP;
            2'b01: next_state = opmc_pkg::OPMC_IDLE_SUB_ONLY;
            2'b11: next_state = opmc_pkg::OPMC_IDLE_BOTH_CLOCKS;
            2'b10: next_state = opmc_pkg::OPMC_IDLE_FAST_ONLY;
          endcase
        end else if (state == opmc_pkg::OPMC_NORMAL) begin
          if (sysctl[7:5] == opmc_pkg::SEL_SUB) begin
            next_state = opmc_pkg::OPMC_SWITCH;
          end
        end else if (state == opmc_pkg::OPMC_SLOW) begin
          if (sysctl[7:5] != opmc_pkg::SEL_SUB) begin
            next_state = opmc_pkg::OPMC_SWITCH;
          end
        end else if (target_stable) begin
          // switch completes once the new source is stable
          next_state = (sysctl[7:5] == opmc_pkg::SEL_SUB) ? opmc_pkg::OPMC_SLOW
                                                          : opmc_pkg::OPMC_NORMAL;
        end
      end
      opmc_pkg::OPMC_SLEEP, opmc_pkg::OPMC_IDLE_SUB_ONLY,
      opmc_pkg::OPMC_IDLE_BOTH_CLOCKS, opmc_pkg::OPMC_IDLE_FAST_ONLY: begin
        if (wake) begin
          next_state = opmc_pkg::OPMC_WAKE;
        end
      end
      opmc_pkg::OPMC_WAKE: begin
        // hold the core until its clock source is stable
        if (target_stable) begin
          next_state = (sysctl[7:5] == opmc_pkg::SEL_SUB) ? opmc_pkg::OPMC_SLOW
                                                          : opmc_pkg::OPMC_NORMAL;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= opmc_pkg::OPMC_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // clock source follows completed switches only; divider loads select on every cycle headed to normal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysclk_use_sub <= 1'b0;
      sysclk_divide  <= 3'h0;
    end else if (next_state == opmc_pkg::OPMC_SLOW) begin
      sysclk_use_sub <= 1'b1;
    end else if (next_state == opmc_pkg::OPMC_NORMAL) begin
      sysclk_use_sub <= 1'b0;
      sysclk_divide  <= sysctl[7:5];
    end
  end

  // ---------------------------------------------------------------
  // status flags and core pulses
  // ---------------------------------------------------------------
  // powerdown and timeout; overflow beats the halt clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerdown_flag        <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end else begin
      if (halt_take) begin
        powerdown_flag <= 1'b1;
      end else if (clr_wdt_exec) begin
        powerdown_flag <= 1'b0;
      end
      if (wdt_overflow) begin
        watchdog_timeout_flag <= 1'b1;
      end else if (halt_take) begin
        watchdog_timeout_flag <= 1'b0;
      end
    end
  end

  // one-cycle pulses to the watchdog and the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_clear    <= 1'b0;
      pc_sp_reset       <= 1'b0;
      resume_after_halt <= 1'b0;
      irq_service       <= 1'b0;
    end else begin
      watchdog_clear <= halt_take || clr_wdt_exec;
      pc_sp_reset    <= halted && wdt_overflow;
      // leaving wake: resume past halt or take the interrupt
      resume_after_halt <= (state == opmc_pkg::OPMC_WAKE) && target_stable &&
                           !wake_by_irq;
      irq_service       <= (state == opmc_pkg::OPMC_WAKE) && target_stable &&
                           wake_by_irq;
    end
  end

  // ---------------------------------------------------------------
  // clock gating and oscillator enables
  // ---------------------------------------------------------------
  // core clock stops in sleep, every idle mode and wake-up
  assign cpu_clock_run        = running;
  assign high_speed_clock_run = !(state == opmc_pkg::OPMC_SLEEP ||
                                  state == opmc_pkg::OPMC_IDLE_SUB_ONLY);
  assign sub_clock_run        = !(state == opmc_pkg::OPMC_SLEEP ||
                                  state == opmc_pkg::OPMC_IDLE_FAST_ONLY);
  assign fast_crystal_osc_en  = fast_xtal_enable && high_speed_clock_run;
  assign slow_crystal_osc_en  = slow_xtal_enable && sub_clock_run;
  // slow rc always runs for the watchdog
  assign slow_rc_osc_en       = 1'b1;

endmodule // opmc_top

// ==== test/opmc_props.sv ====
`timescale 1ns/1ps
module opmc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic halt_exec,
  input wire logic wdt_overflow,
  input wire logic cpu_clock_run,
  input wire logic high_speed_clock_run,
  input wire logic sub_clock_run,
  input wire logic fast_crystal_osc_en,
  input wire logic watchdog_clear,
  input wire logic pc_sp_reset,
  input wire logic resume_after_halt,
  input wire logic irq_service
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_HALT_STOP: assert property (halt_exec && cpu_clock_run |=> !cpu_clock_run [*2])
    else $error("core clock ran on after halt");
  AST_HALT_WDT: assert property (halt_exec && cpu_clock_run |=> watchdog_clear)
    else $error("no watchdog clear after halt");
  AST_PCSP: assert property (pc_sp_reset |-> $past(wdt_overflow))
    else $error("pc and sp reset without overflow");
  AST_SLEEP_CPU: assert property (!high_speed_clock_run && !sub_clock_run |-> !cpu_clock_run)
    else $error("core runs with all clocks off");
  AST_RUN_CLKS: assert property (cpu_clock_run |-> high_speed_clock_run && sub_clock_run)
    else $error("core runs with a clock stopped");
  AST_RESUME: assert property (resume_after_halt |-> cpu_clock_run && !$past(cpu_clock_run))
    else $error("resume not with core clock return");
  AST_SERVE: assert property (irq_service |-> cpu_clock_run && !$past(cpu_clock_run))
    else $error("service not with core clock return");
  AST_XTAL_GATE: assert property (fast_crystal_osc_en |-> high_speed_clock_run)
    else $error("crystal on while fast clock stopped");
  cover property (halt_exec && cpu_clock_run);
  cover property (resume_after_halt);
  cover property (irq_service);
endmodule // opmc_props
bind opmc_top opmc_props u_props (.aclk, .aresetn, .halt_exec, .wdt_overflow, .cpu_clock_run,
  .high_speed_clock_run, .sub_clock_run, .fast_crystal_osc_en, .watchdog_clear, .pc_sp_reset,
  .resume_after_halt, .irq_service);

// ==== test/opmc_osc_model.sv ====
`timescale 1ns/1ps
module opmc_osc_model #(parameter int SETTLE = 20) (
  input  wire logic aclk,
  input  wire logic fast_crystal_osc_en,
  input  wire logic slow_crystal_osc_en,
  output logic      fast_crystal_osc_ready,
  output logic      slow_crystal_osc_ready,
  output logic      fast_rc_osc_ready,
  output logic      slow_rc_osc_ready
);
  int fcnt = 0; // fast crystal settle count
  int scnt = 0; // slow crystal settle count
  // crystals settle after enable, drop at once when stopped
  always @(posedge aclk) begin
    fcnt <= fast_crystal_osc_en ? fcnt + 1 : 0;
    scnt <= slow_crystal_osc_en ? scnt + 1 : 0;
  end
  assign fast_crystal_osc_ready = fcnt >= SETTLE;
  assign slow_crystal_osc_ready = scnt >= 2 * SETTLE; // slower crystal
  assign fast_rc_osc_ready = 1'b1;
  assign slow_rc_osc_ready = 1'b1;
endmodule // opmc_osc_model

// ==== test/opmc_tb_top.sv ====
`timescale 1ns/1ps
module opmc_tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic halt_exec = 0, clr_wdt_exec = 0, wdt_overflow = 0, stack_full = 0;
  logic [7:0] awaddr = 0, araddr = 0, irq_request = 0, irq_enable = 8'hFF, porta_pin = 8'hFF;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, fast_crystal_osc_en, fast_xtal_drive_mode;
  logic slow_crystal_osc_en, slow_xtal_speedup, slow_rc_osc_en, high_speed_clock_run;
  logic sub_clock_run, cpu_clock_run, sysclk_use_sub, watchdog_clear, pc_sp_reset;
  logic resume_after_halt, irq_service, fast_crystal_osc_ready, slow_crystal_osc_ready;
  logic fast_rc_osc_ready, slow_rc_osc_ready;
  logic [2:0] sysclk_divide;
  logic [2:0] sc [4] = '{opmc_pkg::OPMC_SLEEP, opmc_pkg::OPMC_IDLE_SUB_ONLY, opmc_pkg::OPMC_IDLE_FAST_ONLY,
                         opmc_pkg::OPMC_IDLE_BOTH_CLOCKS}; // mode per keep-alive pair
  wire logic [4:0] evs = {!sysclk_use_sub, sysclk_use_sub, irq_service, pc_sp_reset,
                          resume_after_halt};
  int mismatches = 0, samples_checked = 0;
  opmc_top u_dut (.*);
  opmc_osc_model u_osc (.aclk, .fast_crystal_osc_en, .slow_crystal_osc_en,
    .fast_crystal_osc_ready, .slow_crystal_osc_ready, .fast_rc_osc_ready, .slow_rc_osc_ready);
  always #10 aclk = !aclk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // axi4-lite write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata; r = rresp; rready <= 0;
  endtask
  // wait a bounded time for one event line
  task wait_ev(input int i);
    #1;
    for (int n = 0; n < 100 && !evs[i]; n++) begin @(posedge aclk); #1; end
    chk(evs[i], 1);
  endtask
  task halt();
    @(posedge aclk) halt_exec <= 1;
    @(posedge aclk) halt_exec <= 0;
  endtask
  task t_regs();
    rd(8'h00); chk(d, 0);
    rd(8'h20); chk(r, opmc_pkg::RESP_DEC); chk(d, 0);
    wr(8'h20, 1); chk(bresp, opmc_pkg::RESP_DEC);
    wr(8'h04, 4); chk(fast_xtal_drive_mode, 1);
    wr(8'h04, 5); rd(8'h04); chk(d, 5);
    repeat (40) @(posedge aclk);
    rd(8'h04); chk(d, 7);
    wr(8'h04, 1); rd(8'h04); chk(d, 7);
    $display("test regs done");
  endtask
  task t_slow();
    wr(8'h08, 5); chk(slow_xtal_speedup, 1);
    wr(8'h00, 8'hE4); wait_ev(3);
    wr(8'h08, 1); chk(slow_xtal_speedup, 1);
    rd(8'h10); chk(d[5], 1);
    wr(8'h00, 8'h40); wait_ev(4); chk(sysclk_divide, 2);
    $display("test slow done");
  endtask
  task t_halt();
    wr(8'h0C, 1);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, k + 8); halt(); #1;
      chk({slow_rc_osc_en, cpu_clock_run, high_speed_clock_run, sub_clock_run,
           fast_crystal_osc_en, slow_crystal_osc_en}, {2'b10, k[1:0], k[1:0]});
      rd(8'h10); chk(d[4:0], {sc[k], 2'b01});
      @(posedge aclk) porta_pin <= 8'hFE;
      wait_ev(0);
      @(posedge aclk) porta_pin <= 8'hFF;
      @(posedge aclk) clr_wdt_exec <= 1;
      @(posedge aclk) clr_wdt_exec <= 0;
      rd(8'h10); chk(d[0], 0);
    end
    $display("test halt done");
  endtask
  task t_wake();
    irq_request <= 8'h02; halt();
    repeat (10) @(posedge aclk);
    chk(cpu_clock_run, 0);
    irq_request <= 8'h06; wait_ev(2);
    @(posedge aclk) stack_full <= 1;
    halt();
    @(posedge aclk) irq_request <= 8'h0E; wait_ev(0);
    @(posedge aclk) irq_request <= 0;
    stack_full <= 0; halt();
    @(posedge aclk) wdt_overflow <= 1;
    @(posedge aclk) wdt_overflow <= 0;
    wait_ev(1); rd(8'h10); chk(d[1:0], 3);
    halt(); rd(8'h10); chk(d[1:0], 1);
    $display("test wake done");
  endtask
  task test_done();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_regs(); t_slow(); t_halt(); t_wake();
    test_done();
  end
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule // opmc_tb_top
